// *** hw/acmp_ctrl.sv ***
// Control, status and interrupt logic around three analog comparators
//
// Local design decisions: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module acmp_ctrl #(
  parameter int unsigned CHANNELS = acmp_pkg::CHANNELS
) (
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  input  wire logic                         ce_i,
  // Wishbone slave
  input  wire logic                         cyc_i,
  input  wire logic                         stb_i,
  input  wire logic                         we_i,
  input  wire logic [acmp_pkg::ADDR_W-1:0]  adr_i,
  input  wire logic [3:0]                   sel_i,
  input  wire logic [acmp_pkg::DATA_W-1:0]  dat_i,
  output logic      [acmp_pkg::DATA_W-1:0]  dat_o,
  output logic                              ack_o,
  // Analog side
  input  wire logic [CHANNELS-1:0]          cmp_result_i,
  output acmp_pkg::src_sel_t [CHANNELS-1:0] positive_source_select_o,
  output acmp_pkg::ladder_t                 ladder_o,
  output logic      [CHANNELS-1:0]          output_pin_o,
  output logic      [CHANNELS-1:0]          output_pin_oe_o,
  // Controller side
  output logic                              irq_o,
  output logic                              sample_start_o
);

  // Register contents
  acmp_pkg::chan_ctl_t [CHANNELS-1:0] chan_ctl;       // Per-channel control
  acmp_pkg::ref_ctl_t                 ref_ctl;        // Shared reference control
  logic                [CHANNELS-1:0] raw_status;     // Sticky raw interrupt bits
  logic                [CHANNELS-1:0] int_enable;     // Interrupt enable bits

  // Comparator results on the system clock
  logic [CHANNELS-1:0] result_sync;                   // Synchronised compare results
  logic [CHANNELS-1:0] result_prev;                   // Previous synchronised results
  logic [CHANNELS-1:0] event_hit;                     // Interrupt condition this cycle
  logic [CHANNELS-1:0] masked_status;                 // Raw AND enable

  // Bus decoding
  logic                                bus_req;       // New request this cycle
  logic                                bus_wr;        // Write strobe this cycle
  logic                                bus_rd;        // Read strobe this cycle
  logic [acmp_pkg::DATA_W-1:0]         wr_data;       // Write data merged with old value by byte lanes
  logic [acmp_pkg::DATA_W-1:0]         next_dat;      // Read data for the answer
  logic [acmp_pkg::DATA_W-1:0]         old_value;     // Register contents at the address

  // Byte lane merge of write data into a current value
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] lanes);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (lanes[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction : lane_merge

  // Pack a channel's control settings into the register word
  function automatic logic [31:0] ctl_word(input acmp_pkg::chan_ctl_t c);
    logic [31:0] w;
    w = acmp_pkg::RESET_VALUE;
    w[acmp_pkg::CTL_INVERT_BIT]               = c.invert;
    w[acmp_pkg::CTL_SENSE_LSB +: 2]           = c.sense;
    w[acmp_pkg::CTL_LEVEL_BIT]                = c.level;
    w[acmp_pkg::CTL_OUT_EN_BIT]               = c.out_en;
    w[acmp_pkg::CTL_SRC_LSB +: 2]             = c.src;
    return w;
  endfunction : ctl_word

  // Pack the reference settings into the register word
  function automatic logic [31:0] ref_word(input acmp_pkg::ref_ctl_t r);
    logic [31:0] w;
    w = acmp_pkg::RESET_VALUE;
    w[acmp_pkg::REF_TAP_LSB +: 4]             = r.tap;
    w[acmp_pkg::REF_RANGE_BIT]                = r.range_high;
    w[acmp_pkg::REF_EN_BIT]                   = r.en;
    return w;
  endfunction : ref_word

  // Address of a channel's status register
  function automatic logic [7:0] stat_addr(input int unsigned ch);
    return acmp_pkg::OFS_STAT0 + 8'(ch) * acmp_pkg::OFS_CH_STEP;
  endfunction : stat_addr

  // Address of a channel's control register
  function automatic logic [7:0] ctl_addr(input int unsigned ch);
    return acmp_pkg::OFS_CTL0 + 8'(ch) * acmp_pkg::OFS_CH_STEP;
  endfunction : ctl_addr

  acmp_sync #(
    .WIDTH (CHANNELS)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .async_i (cmp_result_i),
    .sync_o  (result_sync)
  );

  acmp_ladder u_ladder (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .ce_i     (ce_i),
    .ref_i    (ref_ctl),
    .ladder_o (ladder_o)
  );

  // A request is answered once, ack drops the cycle after
  assign bus_req = cyc_i && stb_i && !ack_o;
  // Writes land at the edge where the master samples ack high,
  // so a write never takes effect before the master sees it answered
  assign bus_wr  = cyc_i && stb_i && we_i && ack_o;
  // Read data is latched one edge early and stands with ack
  assign bus_rd  = bus_req && !we_i;

  // Previous results for edge sensing
  // Reset level matches the synchroniser, so no false edge follows reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_prev <= '0;
    end else if (ce_i) begin
      result_prev <= result_sync;
    end
  end

  // Per-channel interrupt condition from the sense mode
  always_comb begin
    for (int c = 0; c < CHANNELS; c++) begin
      case (chan_ctl[c].sense)
        // Level sense follows the chosen level
        acmp_pkg::SENSE_LEVEL:   event_hit[c] = (result_sync[c] == chan_ctl[c].level);
        // Edges compare against the previous synchronised result
        acmp_pkg::SENSE_FALLING: event_hit[c] = result_prev[c] && !result_sync[c];
        acmp_pkg::SENSE_RISING:  event_hit[c] = !result_prev[c] && result_sync[c];
        // Either edge
        acmp_pkg::SENSE_BOTH:    event_hit[c] = result_prev[c] ^ result_sync[c];
        // Unreachable with a two-bit code
        default:                 event_hit[c] = 1'b0;
      endcase
    end
  end

  // Masked bits are a view, not storage
  // masked is raw AND enable
  assign masked_status = raw_status & int_enable;

  // Current register contents at the bus address
  always_comb begin
    old_value = acmp_pkg::RESET_VALUE;
    case (adr_i)
      acmp_pkg::OFS_MASKED:  old_value[CHANNELS-1:0] = masked_status;
      acmp_pkg::OFS_RAW:     old_value[CHANNELS-1:0] = raw_status;
      acmp_pkg::OFS_INT_EN:  old_value[CHANNELS-1:0] = int_enable;
      // Shared reference settings
      acmp_pkg::OFS_REF_CTL: old_value = ref_word(ref_ctl);
      default: begin
        for (int c = 0; c < CHANNELS; c++) begin
          // Control word at this channel's control address
          if (adr_i == ctl_addr(c)) begin
            old_value = ctl_word(chan_ctl[c]);
          end
          if (adr_i == stat_addr(c)) begin
            old_value[acmp_pkg::STAT_OUTPUT_VALUE_BIT_BIT] = result_sync[c];
          end
        end
      end
    endcase
  end

  // Write data merged by byte lanes; read data as held
  assign wr_data  = lane_merge(old_value, dat_i, sel_i);
  assign next_dat = old_value;

  // Bus answer, one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= acmp_pkg::RESET_VALUE;
    end else if (ce_i) begin
      ack_o <= bus_req;
      // Read data stands until the next read answer
      if (bus_rd) begin
        dat_o <= next_dat;
      end
    end
  end

  // Interrupt enable register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_enable <= '0;
    end else if (ce_i) begin
      // Bits above the channel count are dropped
      // enable register written
      if (bus_wr && adr_i == acmp_pkg::OFS_INT_EN) begin
        int_enable <= wr_data[CHANNELS-1:0];
      end
    end
  end

  // Reference control register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_ctl <= '0;
    end else if (ce_i) begin
      // Each field taken from its own bit position
      // one reference control
      if (bus_wr && adr_i == acmp_pkg::OFS_REF_CTL) begin
        ref_ctl.tap        <= wr_data[acmp_pkg::REF_TAP_LSB +: 4];
        ref_ctl.range_high <= wr_data[acmp_pkg::REF_RANGE_BIT];
        ref_ctl.en         <= wr_data[acmp_pkg::REF_EN_BIT];
      end
    end
  end

  // Channel control registers, one per channel
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chan_ctl <= '0;
    end else if (ce_i) begin
      for (int c = 0; c < CHANNELS; c++) begin
        if (bus_wr && adr_i == ctl_addr(c)) begin
          // Only the addressed channel changes
          chan_ctl[c].invert <= wr_data[acmp_pkg::CTL_INVERT_BIT];
          chan_ctl[c].sense  <= acmp_pkg::sense_t'(wr_data[acmp_pkg::CTL_SENSE_LSB +: 2]);
          chan_ctl[c].level  <= wr_data[acmp_pkg::CTL_LEVEL_BIT];
          chan_ctl[c].out_en <= wr_data[acmp_pkg::CTL_OUT_EN_BIT];
          chan_ctl[c].src    <= acmp_pkg::src_sel_t'(wr_data[acmp_pkg::CTL_SRC_LSB +: 2]);
        end
      end
    end
  end

  // Sticky raw status: event sets, write one to masked clears, set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      raw_status <= '0;
    end else if (ce_i) begin
      for (int c = 0; c < CHANNELS; c++) begin
        // Level sense re-sets the bit while its level holds
        // raw set regardless of enable
        if (event_hit[c]) begin
          raw_status[c] <= 1'b1;
        end else if (bus_wr && adr_i == acmp_pkg::OFS_MASKED && sel_i[0] && dat_i[c]) begin
          raw_status[c] <= 1'b0;
        end
      end
    end
  end

  // line is OR of masked bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else if (ce_i) begin
      // Registered so the line cannot glitch
      irq_o <= |masked_status;
    end
  end

  // capture start on new enabled event
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sample_start_o <= 1'b0;
    end else if (ce_i) begin
      // Only a bit going from clear to set starts a capture
      sample_start_o <= |(event_hit & ~raw_status & int_enable);
    end
  end

  // Positive source selection to the analog muxes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      positive_source_select_o <= '0;
    end else if (ce_i) begin
      for (int c = 0; c < CHANNELS; c++) begin
        // channel zero never takes another pin
        if (c == 0 && chan_ctl[c].src == acmp_pkg::SRC_OWN_ALT) begin
          positive_source_select_o[c] <= acmp_pkg::SRC_OWN_PIN;
        end else begin
          // Reserved code 11 is passed on unchanged
          positive_source_select_o[c] <= chan_ctl[c].src;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      output_pin_o    <= '0;
      output_pin_oe_o <= '0;
    end else if (ce_i) begin
      for (int c = 0; c < CHANNELS; c++) begin
        // Invert applies to the pin only, not to status
        output_pin_o[c] <= result_sync[c] ^ chan_ctl[c].invert;
        // shared pin left undriven when it is the input
        if (c != 0 && chan_ctl[c].src == acmp_pkg::SRC_OWN_PIN) begin
          output_pin_oe_o[c] <= 1'b0;
        end else begin
          output_pin_oe_o[c] <= chan_ctl[c].out_en;
        end
      end
    end
  end

endmodule : acmp_ctrl
`default_nettype wire

// *** hw/acmp_ladder.sv ***
// Tap decoding for the internal reference resistor ladder
`timescale 1ns/100ps
`default_nettype none
module acmp_ladder (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  input  wire acmp_pkg::ref_ctl_t ref_i,
  output acmp_pkg::ladder_t      ladder_o
);

  // Ladder setting from enable, range and tap code
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ladder_o <= '0;
    end else if (ce_i) begin
      if (!ref_i.en) begin
        ladder_o.en    <= 1'b0;
        ladder_o.tap   <= 5'h00;
        ladder_o.total <= ref_i.range_high ? acmp_pkg::LADDER_TOTAL_HIGH : acmp_pkg::LADDER_TOTAL_LOW;
      end else if (ref_i.range_high) begin
        ladder_o.en    <= 1'b1;
        ladder_o.tap   <= {1'b0, ref_i.tap};
        ladder_o.total <= acmp_pkg::LADDER_TOTAL_HIGH;
      end else begin
        ladder_o.en    <= 1'b1;
        ladder_o.tap   <= {1'b0, ref_i.tap} + acmp_pkg::LADDER_OFFSET;
        ladder_o.total <= acmp_pkg::LADDER_TOTAL_LOW;
      end
    end
  end

endmodule : acmp_ladder
`default_nettype wire

// *** hw/acmp_pkg.sv ***
// Constants, register map and field layouts of the comparator control block
package acmp_pkg;

  // Channel count and register bus geometry
  localparam int unsigned CHANNELS    = 3;
  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned DATA_W      = 32;

  // Register byte offsets
  localparam logic [7:0] OFS_MASKED   = 8'h00;
  localparam logic [7:0] OFS_RAW      = 8'h04;
  localparam logic [7:0] OFS_INT_EN   = 8'h08;
  localparam logic [7:0] OFS_REF_CTL  = 8'h10;
  localparam logic [7:0] OFS_STAT0    = 8'h20;
  localparam logic [7:0] OFS_CTL0     = 8'h24;
  localparam logic [7:0] OFS_CH_STEP  = 8'h20;

  // Channel control register fields
  localparam int unsigned CTL_INVERT_BIT   = 1;
  localparam int unsigned CTL_SENSE_LSB    = 2;
  localparam int unsigned CTL_LEVEL_BIT    = 4;
  localparam int unsigned CTL_OUT_EN_BIT   = 8;
  localparam int unsigned CTL_SRC_LSB      = 9;

  // Channel status register field
  localparam int unsigned STAT_OUTPUT_VALUE_BIT_BIT    = 1;

  // Reference control register fields
  localparam int unsigned REF_TAP_LSB      = 0;
  localparam int unsigned REF_RANGE_BIT    = 8;
  localparam int unsigned REF_EN_BIT       = 9;

  // Ladder geometry
  localparam logic [4:0] LADDER_OFFSET     = 5'h08;
  localparam logic [5:0] LADDER_TOTAL_LOW  = 6'h20;
  localparam logic [5:0] LADDER_TOTAL_HIGH = 6'h18;

  // Reset value of every register
  localparam logic [31:0] RESET_VALUE      = 32'h0000_0000;

  // Positive input source codes
  typedef enum logic [1:0] {
    SRC_OWN_PIN  = 2'b00,
    SRC_OWN_ALT  = 2'b01,
    SRC_INTERNAL = 2'b10,
    SRC_RESERVED = 2'b11
  } src_sel_t;

  // Interrupt sense modes
  typedef enum logic [1:0] {
    SENSE_LEVEL   = 2'b00,
    SENSE_FALLING = 2'b01,
    SENSE_RISING  = 2'b10,
    SENSE_BOTH    = 2'b11
  } sense_t;

  // One channel's control settings
  typedef struct packed {
    src_sel_t src;
    logic     out_en;
    logic     level;
    sense_t   sense;
    logic     invert;
  } chan_ctl_t;

  // Shared reference settings
  typedef struct packed {
    logic       en;
    logic       range_high;
    logic [3:0] tap;
  } ref_ctl_t;

  // Setting delivered to the resistor ladder
  typedef struct packed {
    logic       en;
    logic [4:0] tap;
    logic [5:0] total;
  } ladder_t;

endpackage : acmp_pkg

// *** hw/acmp_sync.sv ***
// Two-stage synchroniser for the asynchronous compare results
`timescale 1ns/100ps
`default_nettype none
module acmp_sync #(
  parameter int unsigned WIDTH = 3
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  // First stage, read only by the second
  logic [WIDTH-1:0] meta;

  // Each bit gets its own two flops
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          meta[g]   <= 1'b0;
          sync_o[g] <= 1'b0;
        end else if (ce_i) begin
          meta[g]   <= async_i[g];
          sync_o[g] <= meta[g];
        end
      end
    end
  endgenerate

endmodule : acmp_sync
`default_nettype wire

// *** verification/acmp_analog.sv ***
// Analog world at the comparator pins: voltages, ladder and compare
`timescale 1ns/100ps
`default_nettype none
module acmp_analog #(
  parameter int SUPPLY_MV = 3300
) (
  input wire logic [2:0][15:0]        neg_mv_i,
  input wire logic [2:0][15:0]        pos_mv_i,
  input wire acmp_pkg::src_sel_t [2:0] src_i,
  input wire acmp_pkg::ladder_t       ladder_i,
  output logic [2:0]                  result_o
);
  logic [15:0] vref_mv;  // Ladder output
  logic [15:0] pos_sel;  // Chosen positive input
  always_comb begin
    vref_mv = 16'h0000;
    if (ladder_i.en && ladder_i.total != 6'h00) begin
      vref_mv = 16'(SUPPLY_MV * ladder_i.tap / ladder_i.total);
    end
  end
  // pads carry no digital input path here
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      case (src_i[i])
        acmp_pkg::SRC_OWN_PIN: pos_sel = pos_mv_i[i];
        acmp_pkg::SRC_OWN_ALT: pos_sel = pos_mv_i[0];
        acmp_pkg::SRC_INTERNAL: pos_sel = vref_mv;
        default: pos_sel = 16'h0000;
      endcase
      result_o[i] = neg_mv_i[i] < pos_sel;
    end
  end
endmodule : acmp_analog
`default_nettype wire

// *** verification/acmp_ctrl_bench.sv ***
// Self-checking bench for the comparator control block
`timescale 1ns/100ps
`default_nettype none
module acmp_ctrl_bench;
  localparam int SUPPLY = 3300;            // Analog supply in millivolts
  logic              clk_i = 1'b0;         // System clock
  logic              rst_i = 1'b1;         // Synchronous reset
  logic              cyc_i = 1'b0;         // Bus cycle
  logic              stb_i = 1'b0;         // Bus strobe
  logic              we_i = 1'b0;          // Bus direction
  logic [7:0]        adr_i = 8'h00;        // Bus address
  logic [31:0]       dat_i = 32'h0000_0000;
  logic [31:0]       dat_o;
  logic              ack_o;
  logic [2:0]        cmp;                  // Compare results
  acmp_pkg::src_sel_t [2:0] src;
  acmp_pkg::ladder_t ladder;
  logic [2:0]        pin;
  logic [2:0]        oe;
  logic              irq_o;
  logic              sample_start_o;
  logic [2:0][15:0]  neg_mv = {3{16'h0bb8}};  // Negative pins high
  logic [2:0][15:0]  pos_mv = '0;
  logic [31:0]       rd;
  logic [9:0]        r;
  logic [15:0]       v;
  logic [15:0]       vr;
  logic              exp_res;
  logic              inv;                  // Random output invert
  int                err_count = 0;
  int                compares = 0;
  int                starts = 0;           // Capture-start pulses seen
  logic [7:0]        addrs [11] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h20, 8'h24,
                                    8'h40, 8'h44, 8'h60, 8'h64, 8'h0c};

  acmp_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .cmp_result_i(cmp), .positive_source_select_o(src), .ladder_o(ladder),
    .output_pin_o(pin), .output_pin_oe_o(oe), .irq_o(irq_o), .sample_start_o(sample_start_o));
  acmp_analog #(.SUPPLY_MV(SUPPLY)) analog (.neg_mv_i(neg_mv), .pos_mv_i(pos_mv),
    .src_i(src), .ladder_i(ladder), .result_o(cmp));

  // Clock at 50 MHz
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  // Count capture-start pulses
  always @(posedge clk_i) begin
    if (sample_start_o === 1'b1) starts <= starts + 1;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Classic single bus cycle, waits for the answer
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    if (n >= 50) err_count++;
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  function automatic logic [7:0] chan(input int ch, input logic [7:0] base);
    return 8'(base + ch * acmp_pkg::OFS_CH_STEP);
  endfunction : chan

  // Expected ladder setting from a reference control value
  function automatic logic [11:0] exp_ladder(input logic [9:0] c);
    if (!c[9]) return {6'h00, c[8] ? 6'h18 : 6'h20};
    if (c[8]) return {2'b10, c[3:0], 6'h18};
    return {1'b1, 5'(c[3:0] + 5'h08), 6'h20};
  endfunction : exp_ladder

  // Expected reference voltage in millivolts
  function automatic logic [15:0] ref_mv(input logic [9:0] c);
    if (c[8]) return 16'(SUPPLY * c[3:0] / 24);
    return 16'(SUPPLY * (c[3:0] + 8) / 32);
  endfunction : ref_mv

  task automatic print_verdict();
    if (err_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    print_verdict();
  end

  initial begin
    rd = $urandom(32'h1ebd);
    tick(10);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // reset values and unmapped hole; level-low sense sets raw bits at once
    foreach (addrs[i]) begin
      wb(0, addrs[i], 0, rd);
      check(rd, (addrs[i] == acmp_pkg::OFS_RAW) ? 7 : 0);
    end
    // Random write and read back, unmapped write ignored
    for (int i = 0; i < 5; i++) begin
      v = 16'($urandom & 32'h0000_071e);
      wb(1, chan(i % 3, acmp_pkg::OFS_CTL0), 32'(v), rd);
      wb(0, chan(i % 3, acmp_pkg::OFS_CTL0), 0, rd);
      check(rd, 32'(v));
      wb(1, 8'h0c, $urandom, rd);
      wb(0, 8'h0c, 0, rd);
      check(rd, 0);
    end
    // Every source code on every channel, output enabled
    for (int ch = 0; ch < 3; ch++) begin
      for (int c = 0; c < 4; c++) begin
        // shared pin used as input only with code 00
        wb(1, chan(ch, acmp_pkg::OFS_CTL0), 32'h0000_0100 | 32'(c << 9), rd);
        tick(3);
        check(src[ch], (ch == 0 && c == 1) ? 0 : c);
        check(oe[ch], (ch != 0 && c == 0) ? 0 : 1);
      end
    end
    // All reference settings
    for (int k = 0; k < 64; k++) begin
      r = {k[5:4], 4'h0, k[3:0]};
      wb(1, acmp_pkg::OFS_REF_CTL, 32'(r), rd);
      tick(3);
      check(ladder, exp_ladder(r));
    end
    // Channel zero against a random reference, random invert
    for (int i = 0; i < 10; i++) begin
      r = {2'b11, 4'h0, 4'($urandom)};
      r[8] = 1'($urandom);
      vr = ref_mv(r);
      inv = 1'($urandom);
      wb(1, acmp_pkg::OFS_REF_CTL, 32'(r), rd);
      wb(1, acmp_pkg::OFS_CTL0, 32'h0000_0500 | {30'h0, inv, 1'b0}, rd);
      tick(6);
      exp_res = pin[0];
      v = 16'($urandom_range(0, SUPPLY - 1));
      if (v == vr) v = v + 16'h0001;
      neg_mv[0] <= v;
      // Two sync flops and the pin flop: still old three edges on
      tick(3);
      check(pin[0], exp_res);
      tick(3);
      wb(0, acmp_pkg::OFS_STAT0, 0, rd);
      check(rd[acmp_pkg::STAT_OUTPUT_VALUE_BIT_BIT], v < vr);
      wb(0, acmp_pkg::OFS_CTL0, 0, rd);
      check(rd, 32'h0000_0500 | {30'h0, inv, 1'b0});
      check(pin[0], (v < vr) ^ inv);
    end
    // Rising event on channel one from channel zero's pin
    pos_mv[0] <= 16'h07d0;
    neg_mv[1] <= 16'h09c4;
    wb(1, chan(1, acmp_pkg::OFS_CTL0), 32'h0000_0208, rd);
    wb(1, acmp_pkg::OFS_INT_EN, 32'h0000_0002, rd);
    tick(6);
    wb(1, acmp_pkg::OFS_MASKED, 32'h0000_0007, rd);
    neg_mv[1] <= 16'h03e8;
    tick(8);
    check(starts, 1);
    check(irq_o, 1);
    wb(0, acmp_pkg::OFS_MASKED, 0, rd);
    check(rd, 2);
    wb(1, acmp_pkg::OFS_MASKED, 0, rd);
    wb(1, acmp_pkg::OFS_INT_EN, 0, rd);
    tick(3);
    check(irq_o, 0);
    // Channels zero and two stay in level-low sense and re-set when low
    wb(0, acmp_pkg::OFS_RAW, 0, rd);
    check(rd, 32'({2'b11, v >= vr}));
    wb(1, acmp_pkg::OFS_MASKED, 32'h0000_0002, rd);
    wb(0, acmp_pkg::OFS_RAW, 0, rd);
    check(rd, 32'({2'b10, v >= vr}));
    // Level sense on channel two re-sets after a clear
    pos_mv[2] <= 16'h0bb8;
    neg_mv[2] <= 16'h0064;
    wb(1, chan(2, acmp_pkg::OFS_CTL0), 32'h0000_0010, rd);
    tick(6);
    wb(1, acmp_pkg::OFS_MASKED, 32'h0000_0004, rd);
    tick(4);
    wb(0, acmp_pkg::OFS_RAW, 0, rd);
    check(rd, 32'({2'b10, v >= vr}));
    check(irq_o, 0);
    wb(1, acmp_pkg::OFS_INT_EN, 32'h0000_0004, rd);
    tick(3);
    check(irq_o, 1);
    check(starts, 1);
    // Both-edge sense catches a falling result on channel one
    wb(1, chan(1, acmp_pkg::OFS_CTL0), 32'h0000_020c, rd);
    neg_mv[1] <= 16'h09c4;
    tick(6);
    wb(0, acmp_pkg::OFS_RAW, 0, rd);
    check(rd[1], 1);
    print_verdict();
  end
endmodule : acmp_ctrl_bench

bind acmp_ctrl acmp_ctrl_chk #(.CHANNELS(CHANNELS)) chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
  .positive_source_select_o(positive_source_select_o), .ladder_o(ladder_o),
  .output_pin_oe_o(output_pin_oe_o), .irq_o(irq_o), .sample_start_o(sample_start_o));
`default_nettype wire

// *** verification/acmp_ctrl_chk.sv ***
// Port-level assertions for the comparator control block
`timescale 1ns/100ps
`default_nettype none
module acmp_ctrl_chk #(
  parameter int unsigned CHANNELS = acmp_pkg::CHANNELS
) (
  input wire logic                         clk_i,
  input wire logic                         rst_i,
  input wire logic                         ce_i,
  input wire logic                         cyc_i,
  input wire logic                         stb_i,
  input wire logic [acmp_pkg::DATA_W-1:0]  dat_o,
  input wire logic                         ack_o,
  input wire acmp_pkg::src_sel_t [CHANNELS-1:0] positive_source_select_o,
  input wire acmp_pkg::ladder_t            ladder_o,
  input wire logic [CHANNELS-1:0]          output_pin_oe_o,
  input wire logic                         irq_o,
  input wire logic                         sample_start_o
);
  // One clock domain; reset or a low clock enable disables every relation
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i || !ce_i);

  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("bus answer lasted more than one cycle");
  ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("bus request not answered next cycle");
  ack_cause_a: assert property ($rose(ack_o) |-> $past(stb_i))
    else $error("bus answer without a request");
  read_hold_a: assert property (!ack_o |-> $stable(dat_o))
    else $error("read data moved without an answer");
  ladder_off_a: assert property (!ladder_o.en |-> ladder_o.tap == 5'h00)
    else $error("disabled ladder not at ground tap");
  ladder_range_a: assert property (ladder_o.en |->
      (ladder_o.total == 6'h20 && ladder_o.tap >= 5'h08 && ladder_o.tap <= 5'h17) ||
      (ladder_o.total == 6'h18 && ladder_o.tap <= 5'h0f))
    else $error("ladder tap outside its range");
  src_zero_a: assert property (positive_source_select_o[0] != acmp_pkg::SRC_OWN_ALT)
    else $error("channel zero sent the alternate source code");
  oe_one_a: assert property ((positive_source_select_o[1] == acmp_pkg::SRC_OWN_PIN)[*3] |-> !output_pin_oe_o[1])
    else $error("channel one drives its shared input pin");
  oe_two_a: assert property ((positive_source_select_o[2] == acmp_pkg::SRC_OWN_PIN)[*3] |-> !output_pin_oe_o[2])
    else $error("channel two drives its shared input pin");
  sample_irq_a: assert property (sample_start_o |-> ##[0:2] irq_o)
    else $error("capture start without controller interrupt");

  // Main scenarios reached
  irq_seen_c: cover property ($rose(irq_o));
  start_seen_c: cover property (sample_start_o);
  ladder_high_c: cover property (ladder_o.en && ladder_o.total == 6'h18);
endmodule : acmp_ctrl_chk
`default_nettype wire
